// >>> src/arfc_pkg.sv
// Package for the 16x4 register file controller
package arfc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 4;
  localparam int unsigned WORDS      = 16;
  localparam int unsigned NUM_DEV    = 2;
  localparam int unsigned SYS_ADDR_W = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS      = 25000;
  localparam int unsigned SELECT_PULSE_MIN_PS = 18000;
  localparam int unsigned SELECT_PULSE_CYC   =
    (SELECT_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READ_WAIT_CYC      = 1;
  localparam int unsigned CNT_W              = 4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic                  write;
    logic [SYS_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     data;
  } arfc_req_s;

  typedef struct packed {
    logic [NUM_DEV-1:0] select_n;
    logic               write_strobe_n;
    logic [ADDR_W-1:0]  word_address;
    logic [DATA_W-1:0]  write_data_in;
  } arfc_pins_s;

endpackage

// >>> src/arfc_bus_merge.sv
// Wired-OR merge of the device read buses
`timescale 1ns/1ps
module arfc_bus_merge
#(
  parameter int unsigned N = 2,
  parameter int unsigned W = 4
)
(
  // Device outputs, flattened
  input  wire logic [N*W-1:0] dev_q,
  // Merged bus
  output logic      [W-1:0]   merged
);

  always_comb
  begin
    merged = '0;
    for (int i = 0; i < N; i++)
    begin
      merged = merged | dev_q[i*W +: W];
    end
  end

endmodule

// >>> src/arfc_ctrl.sv
// Controller driving two 16x4 register files as a 32-word memory
//
// Operation
// - Controller drives a fully decoded 4-bit word address.
// - Extra address bit decodes onto the two separate selects.
// - At most one device selected on the shared wired-OR bus.
// - Strobe-select write: set pins first, select low at least 18 ns.
`timescale 1ns/1ps
module arfc_ctrl
(
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  // User request
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire arfc_pkg::arfc_req_s            req,
  // User read answer
  output logic                                rsp_valid,
  output logic [arfc_pkg::DATA_W-1:0]         rsp_data,
  // Device pins
  output arfc_pkg::arfc_pins_s                pins,
  input  wire logic [arfc_pkg::NUM_DEV*arfc_pkg::DATA_W-1:0] read_data_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD  = 4'b1000
  } arfc_state_e;

  arfc_state_e                  state;
  arfc_state_e                  next_state;
  arfc_pkg::arfc_req_s          cur;
  logic [arfc_pkg::CNT_W-1:0]   cnt;
  logic [arfc_pkg::DATA_W-1:0]  merged;

  // Decode the top address bit into active-low selects
  function automatic logic [arfc_pkg::NUM_DEV-1:0] sel_decode
    (input logic top);
    sel_decode = top ? 2'h1 : 2'h2;
  endfunction

  localparam logic [arfc_pkg::CNT_W-1:0] PULSE_LAST =
    arfc_pkg::CNT_W'(arfc_pkg::SELECT_PULSE_CYC - 1);
  localparam logic [arfc_pkg::CNT_W-1:0] READ_LAST =
    arfc_pkg::CNT_W'(arfc_pkg::READ_WAIT_CYC);

  assign req_ready = (state == ST_IDLE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:  if (req_valid) next_state = ST_SETUP;
      ST_SETUP: next_state = ST_PULSE;
      ST_PULSE:
      begin
        if ((cur.write && cnt == PULSE_LAST) ||
            (!cur.write && cnt == READ_LAST))
          next_state = ST_HOLD;
      end
      ST_HOLD:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cnt <= '0;
    else if (state == ST_PULSE)
      cnt <= cnt + 4'h1;
    else
      cnt <= '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cur <= '0;
    else if (state == ST_IDLE && req_valid)
      cur <= req;
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pins.select_n       <= '1;
      pins.write_strobe_n <= 1'b1;
      pins.word_address   <= '0;
      pins.write_data_in  <= '0;
    end
    else
    begin
      case (next_state)
        ST_SETUP:
        begin
          pins.word_address   <= req.addr[arfc_pkg::ADDR_W-1:0];
          pins.write_data_in  <= req.data;
          pins.write_strobe_n <= ~req.write;
          pins.select_n       <= '1;
        end
        ST_PULSE:
          pins.select_n <= sel_decode(cur.addr[arfc_pkg::ADDR_W]);
        ST_HOLD:
          pins.select_n <= '1;
        default:
        begin
          pins.select_n       <= '1;
          pins.write_strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read capture
  // ****************************************************************
  arfc_bus_merge #(
    .N (arfc_pkg::NUM_DEV),
    .W (arfc_pkg::DATA_W)
  ) u_merge (
    .dev_q  (read_data_out),
    .merged (merged)
  );

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state == ST_PULSE && !cur.write && cnt == READ_LAST)
      begin
        rsp_valid <= 1'b1;
        rsp_data  <= merged;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [arfc_pkg::CNT_W-1:0]   sel_low_cnt;

  localparam logic [arfc_pkg::CNT_W-1:0] SEL_MIN =
    arfc_pkg::CNT_W'(arfc_pkg::SELECT_PULSE_CYC);

  // Length of the current select pulse
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      sel_low_cnt <= '0;
    else if (!(&pins.select_n))
      sel_low_cnt <= sel_low_cnt + 4'h1;
    else
      sel_low_cnt <= '0;
  end

  property p_one_select;
    @(posedge core_clk) disable iff (sys_rst)
      !(pins.select_n[0] == 1'b0 && pins.select_n[1] == 1'b0);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("both devices selected");

  property p_strobe_stable;
    @(posedge core_clk) disable iff (sys_rst)
      (!(&pins.select_n)) |-> $stable(pins.write_strobe_n)
        && $stable(pins.word_address) && $stable(pins.write_data_in);
  endproperty
  a_strobe_stable: assert property (p_strobe_stable)
    else $error("pins changed while selected");

  property p_select_width;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(&pins.select_n) && !pins.write_strobe_n
        |-> sel_low_cnt >= SEL_MIN;
  endproperty
  a_select_width: assert property (p_select_width)
    else $error("select pulse too short");

  property p_decode;
    @(posedge core_clk) disable iff (sys_rst)
      (!(&pins.select_n)) |->
        pins.select_n == sel_decode(cur.addr[arfc_pkg::ADDR_W]);
  endproperty
  a_decode: assert property (p_decode)
    else $error("wrong device selected");

  property p_idle_strobe;
    @(posedge core_clk) disable iff (sys_rst)
      (state == ST_IDLE) |-> pins.write_strobe_n && (&pins.select_n);
  endproperty
  a_idle_strobe: assert property (p_idle_strobe)
    else $error("pins active while idle");

  property p_read_answer;
    @(posedge core_clk) disable iff (sys_rst)
      (req_valid && req_ready && !req.write) |-> ##4 rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");

  property p_addr_drive;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(&pins.select_n) |->
        pins.word_address == cur.addr[arfc_pkg::ADDR_W-1:0];
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("address not driven");

  property p_write_no_rsp;
    @(posedge core_clk) disable iff (sys_rst)
      (req_valid && req_ready && req.write) |=> !rsp_valid [*4];
  endproperty
  a_write_no_rsp: assert property (p_write_no_rsp)
    else $error("write gave answer");

endmodule

// >>> tb/arfc_dev_model.sv
// Behavioural model of one 16x4 register file
`timescale 1ns/1ps
module arfc_dev_model
(
  // Device pins
  input  wire logic       select_n,
  input  wire logic       write_strobe_n,
  input  wire logic [3:0] word_address,
  input  wire logic [3:0] write_data_in,
  // Read output
  output logic      [3:0] read_data_out
);
  // Sixteen words, kept until written
  logic [3:0] mem [16];
  always @*
  begin
    if (select_n === 1'b0 && write_strobe_n === 1'b0)
    begin
      mem[word_address] = write_data_in;
    end
  end
  assign read_data_out = (select_n !== 1'b0) ? 4'h0 :
    (write_strobe_n !== 1'b1) ? 4'h0 : mem[word_address];
endmodule

// >>> tb/arfc_ctrl_test.sv
// Self-checking bench for the register file controller
`timescale 1ns/1ps
module arfc_ctrl_test;
  logic                 core_clk;
  logic                 sys_rst;
  logic                 req_valid;
  logic                 req_ready;
  arfc_pkg::arfc_req_s  req;
  logic                 rsp_valid;
  logic [3:0]           rsp_data;
  arfc_pkg::arfc_pins_s pins;
  wire [7:0]            q;
  int                   mismatches;
  int                   checks_done;
  int                   cycles;
  int                   ref_mem [32];
  logic [31:0]          lfsr;

  // ****************************************************************
  // Design and two devices
  // ****************************************************************
  arfc_ctrl dut
  (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .req_valid     (req_valid),
    .req_ready     (req_ready),
    .req           (req),
    .rsp_valid     (rsp_valid),
    .rsp_data      (rsp_data),
    .pins          (pins),
    .read_data_out (q)
  );
  for (genvar i = 0; i < 2; i++)
  begin : g_dev
    arfc_dev_model u_dev
    (
      .select_n       (pins.select_n[i]),
      .write_strobe_n (pins.write_strobe_n),
      .word_address   (pins.word_address),
      .write_data_in  (pins.write_data_in),
      .read_data_out  (q[i*4 +: 4])
    );
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [4:0] a, input logic [3:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{write: w, addr: a, data: d};
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 1;
    if (w)
    begin
      ref_mem[a] = int'(d);
      while (req_ready !== 1'b1 && n < 8)
      begin
        @(negedge core_clk);
        n++;
      end
      check(4'(n), 4'h4);
      return;
    end
    while (rsp_valid !== 1'b1 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    check(4'(n), 4'h4);
    check(rsp_data, 4'(ref_mem[a]));
  endtask

  // ****************************************************************
  // Clock, watchdog, bus watch
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  always @(negedge core_clk)
  begin
    if (!sys_rst)
    begin
      check(4'(pins.select_n === 2'b00), 4'h0);
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lfsr = 32'h8c5e9a72;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    check({2'b00, pins.select_n}, 4'h3);
    check({3'b000, req_ready}, 4'h1);
    for (int a = 0; a < 32; a++)
    begin
      lfsr = next_rand(lfsr);
      xfer(1'b1, 5'(a), lfsr[3:0]);
    end
    for (int a = 31; a >= 0; a--)
      xfer(1'b0, 5'(a), 4'h0);
    $display("test fill and read done");
    for (int k = 0; k < 60; k++)
    begin
      lfsr = next_rand(lfsr);
      xfer(lfsr[9], lfsr[8:4], lfsr[3:0]);
    end
    $display("test random mix done");
    tally_and_finish();
  end
endmodule
